// ===== rtl/iob_consts.vh
// Purpose: constants for the I/O break trap block
// Assumes: registers reached through an index/data port pair
// Notes: offsets are index values written to the index port
// Behaviour
// R1: Window 2 enabled traps reads and writes inside window 2 base and size.
// R2: Window 1 enabled traps reads and writes inside window 1 base and size.
// R3: Hard disk trap covers 1F0h-1F7h and 3F6h, reads and writes.
// R4: Floppy trap covers 3F0h-3F5h, reads and writes.
// R5: Parallel port 1 trap covers 378h-37Ah, reads and writes.
// R6: Serial port 2 trap covers 2F8h-2FFh, reads and writes.
// R7: Serial port 1 trap covers 3F8h-3FFh, reads and writes.
// R8: Keyboard read trap covers reads only of 60h, 61h, 64h.
// R9: Keyboard write trap covers writes only to 60h, 61h, 64h.
// R10: CMOS index trap covers writes to 70h, not reads.
// R11: Second DMA trap covers writes to even addresses C0h-DEh.
// R12: First DMA trap covers writes to 00h-0Fh.
// R13: Enable bit 2 of mask B traps writes to 20h-21h.
// R14: Enable bit 1 of mask B traps writes to A0h-A1h.
// R15: Interval timer trap covers writes to 40h-43h.
// R16: Each enabled trap sets its flag at its enable bit position.
// R17: Reading a status register clears all of its bits.
// R18: Break summary bit 6 set while any trap or timer flag set.
// R19: Shared disk address sets both disk flags when both enabled; code sets only the hard disk flag, floppy range ends at 3F5h.
// R20: 10-bit decode ignores base bits 15 to 10 for windows.
// R21: Size field selects 4, 8, 16 or 32 byte windows.
// R22: Software programs base and size before enabling a window.
// R23: Software sets control bit 7 or traps have no effect.
// R24: Lock with management inactive makes mask registers read-only.
// R25: 10-bit decode applies to fixed and programmable ranges.
// R26: Only I/O cycles are decoded, never memory cycles.
`ifndef IOB_CONSTS_VH
`define IOB_CONSTS_VH
`define IOB_IDX_ENABLE_A 8'h80
`define IOB_IDX_ENABLE_B 8'h81
`define IOB_IDX_STATUS_A 8'h82
`define IOB_IDX_STATUS_B 8'h83
`define IOB_IDX_W2_HI 8'h84
`define IOB_IDX_W2_LO 8'h85
`define IOB_IDX_W1_HI 8'h86
`define IOB_IDX_W1_LO 8'h87
`define IOB_MASK_RESET 8'h00
`define IOB_STAT_RESET 8'h00
`define IOB_WIN_RESET 8'h00
`define IOB_CTL_ENABLE_BIT 7
`define IOB_CTL_BREAK_BIT 6
`define IOB_CTL_LOCK_BIT 4
`define IOB_MISC_DEC10_BIT 1
`define IOB_DEC10_MASK 16'h03ff
`define IOB_FULL_MASK 16'hffff
`define IOB_HD_LO 16'h01f0
`define IOB_HD_HI 16'h01f7
`define IOB_HD_ALT 16'h03f6
`define IOB_FD_LO 16'h03f0
`define IOB_FD_HI 16'h03f5
`define IOB_LP1_LO 16'h0378
`define IOB_LP1_HI 16'h037a
`define IOB_SP2_LO 16'h02f8
`define IOB_SP2_HI 16'h02ff
`define IOB_SP1_LO 16'h03f8
`define IOB_SP1_HI 16'h03ff
`define IOB_KBD_DATA 16'h0060
`define IOB_KBD_PORTB 16'h0061
`define IOB_KBD_CMD 16'h0064
`define IOB_CMOS_IDX 16'h0070
`define IOB_DMA2_LO 16'h00c0
`define IOB_DMA2_HI 16'h00de
`define IOB_DMA1_LO 16'h0000
`define IOB_DMA1_HI 16'h000f
`define IOB_IRQB2_LO 16'h0020
`define IOB_IRQB2_HI 16'h0021
`define IOB_IRQB1_LO 16'h00a0
`define IOB_IRQB1_HI 16'h00a1
`define IOB_TMR_LO 16'h0040
`define IOB_TMR_HI 16'h0043
`endif

// ===== rtl/iob_window_match.v
// Purpose: match an I/O address against one programmable window
// Assumes: base and size registers held by the caller
// Notes: purely combinational
`timescale 1ns/100ps
`include "iob_consts.vh"
module iob_window_match
(
	// Window setup
	input wire [7:0] base_high,
	input wire [7:0] base_low_size,
	input wire dec10,
	// Address under test
	input wire [15:0] addr,
	// Result
	output reg hit
);
	reg [15:0] care;
	reg [15:0] base;

	// Size field widens the window by dropping low base bits
	always @*
	begin
		base = {base_high, base_low_size[7:2], 2'b00};
		care = dec10 ? `IOB_DEC10_MASK : `IOB_FULL_MASK; // [R20] [R25]
		care[1:0] = 2'b00;
		case (base_low_size[1:0]) // [R21]
			2'b01: care[2] = 1'b0;
			2'b10: care[3:2] = 2'b00;
			2'b11: care[4:2] = 3'b000;
			default: care[1:0] = 2'b00;
		endcase
		hit = ((addr ^ base) & care) == 16'h0000;
	end
endmodule // iob_window_match

// ===== rtl/iob_pin_sync.v
// Purpose: three-stage synchroniser for pin inputs
// Assumes: a change counts once stages two and three agree
// Notes: stage one feeds stage two only
`timescale 1ns/100ps
module iob_pin_sync
#(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
	// Clock and reset
	input wire mclk,
	input wire reset,
	// Pin side
	input wire [WIDTH-1:0] pin_in,
	// Clean side
	output reg [WIDTH-1:0] level
);
	reg [WIDTH-1:0] s1_reg;
	reg [WIDTH-1:0] s2_reg;
	reg [WIDTH-1:0] s3_reg;
	integer i;

	// Filtered level updates only on agreement, rejecting a single-cycle glitch
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			level <= INIT;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (i = 0; i < WIDTH; i = i + 1)
				if (s2_reg[i] == s3_reg[i])
					level[i] <= s3_reg[i];
		end
	end
endmodule // iob_pin_sync

// ===== rtl/iob_break_trap.v
// Purpose: I/O break trap with mask, status and window registers
// Assumes: one I/O cycle per io_strobe pulse, same clock domain as mclk
// Notes: registers reached by index/data port pair on the same I/O bus
`timescale 1ns/100ps
`include "iob_consts.vh"
module iob_break_trap
#(
	parameter [15:0] INDEX_PORT = 16'h00ec,
	parameter [15:0] DATA_PORT = 16'h00ed
)
(
	// Clock and reset
	input wire mclk,
	input wire reset,
	// Processor bus cycle, one-cycle strobe
	input wire io_strobe,
	input wire io_cycle,
	input wire io_write,
	input wire [15:0] io_addr,
	input wire [7:0] io_wdata,
	// Read answer for data port reads
	output reg [7:0] io_rdata,
	output reg io_rvalid,
	// Control inputs held elsewhere in the chip
	input wire break_enable,
	input wire mgmt_lock,
	input wire io_decode_width_sel,
	input wire timer_flags_any,
	// Management interrupt pin level from outside
	input wire mgmt_irq_pin_n,
	// Outputs
	output reg mgmt_irq_n,
	output reg any_break_pending
);
	reg [7:0] index_reg;
	reg [7:0] trap_enable_a_reg;
	reg [7:0] trap_enable_b_reg;
	reg [7:0] trap_status_a_reg;
	reg [7:0] trap_status_b_reg;
	reg [7:0] window2_base_high_reg;
	reg [7:0] window2_base_low_size_reg;
	reg [7:0] window1_base_high_reg;
	reg [7:0] window1_base_low_size_reg;
	reg [7:0] rdata_next;
	reg [7:0] hit_a;
	reg [7:0] hit_b;
	reg [7:0] status_a_next;
	reg [7:0] status_b_next;
	reg [15:0] dec_addr;
	reg [15:0] ctl_addr;
	reg io_read;
	wire w1_hit;
	wire w2_hit;
	wire pin_level_n;
	wire mgmt_active;
	wire io_cyc;
	wire data_acc;
	wire idx_wr;
	wire data_wr;
	wire data_rd;
	wire mask_wr_ok;

	// Range test used by the fixed decodes other than keyboard, CMOS index and 3F6h
	function in_range;
		input [15:0] a;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	// Keyboard decode shared by read and write traps
	function kbd_port;
		input [15:0] a;
		begin
			kbd_port = (a == `IOB_KBD_DATA) || (a == `IOB_KBD_PORTB) || (a == `IOB_KBD_CMD);
		end
	endfunction

	// Pin level synchronised so the lock decision sees a clean state
	iob_pin_sync #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_pin_sync (
		.mclk(mclk),
		.reset(reset),
		.pin_in(mgmt_irq_pin_n),
		.level(pin_level_n)
	);

	assign mgmt_active = ~pin_level_n;

	iob_window_match u_win1 (
		.base_high(window1_base_high_reg),
		.base_low_size(window1_base_low_size_reg),
		.dec10(io_decode_width_sel),
		.addr(io_addr),
		.hit(w1_hit)
	);

	iob_window_match u_win2 (
		.base_high(window2_base_high_reg),
		.base_low_size(window2_base_low_size_reg),
		.dec10(io_decode_width_sel),
		.addr(io_addr),
		.hit(w2_hit)
	);

	// Memory cycles never reach the decodes
	assign io_cyc = io_strobe & io_cycle; // [R26]
	assign data_acc = io_cyc && (ctl_addr == DATA_PORT);
	assign idx_wr = io_cyc && io_write && (ctl_addr == INDEX_PORT);
	assign data_wr = data_acc & io_write;
	assign data_rd = data_acc & ~io_write;
	// Lock only bites outside management mode
	assign mask_wr_ok = ~mgmt_lock | mgmt_active; // [R24]

	// Address folding for 10-bit decode
	always @*
	begin
		dec_addr = io_addr & (io_decode_width_sel ? `IOB_DEC10_MASK : `IOB_FULL_MASK); // [R25]
		ctl_addr = io_addr;
		io_read = ~io_write;
	end

	// Fixed and programmable hit vectors, bit positions follow the enables
	always @*
	begin
		hit_a = 8'h00;
		hit_b = 8'h00;
		hit_a[6] = w2_hit; // [R1]
		hit_a[5] = w1_hit; // [R2]
		hit_a[4] = in_range(dec_addr, `IOB_HD_LO, `IOB_HD_HI) || (dec_addr == `IOB_HD_ALT); // [R3]
		hit_a[3] = in_range(dec_addr, `IOB_FD_LO, `IOB_FD_HI); // [R4]
		hit_a[2] = in_range(dec_addr, `IOB_LP1_LO, `IOB_LP1_HI); // [R5]
		hit_a[1] = in_range(dec_addr, `IOB_SP2_LO, `IOB_SP2_HI); // [R6]
		hit_a[0] = in_range(dec_addr, `IOB_SP1_LO, `IOB_SP1_HI); // [R7]
		hit_b[7] = io_read && kbd_port(dec_addr); // [R8]
		hit_b[6] = io_write && kbd_port(dec_addr); // [R9]
		hit_b[5] = io_write && (dec_addr == `IOB_CMOS_IDX); // [R10]
		hit_b[4] = io_write && in_range(dec_addr, `IOB_DMA2_LO, `IOB_DMA2_HI) && ~dec_addr[0]; // [R11]
		hit_b[3] = io_write && in_range(dec_addr, `IOB_DMA1_LO, `IOB_DMA1_HI); // [R12]
		hit_b[2] = io_write && in_range(dec_addr, `IOB_IRQB2_LO, `IOB_IRQB2_HI); // [R13]
		hit_b[1] = io_write && in_range(dec_addr, `IOB_IRQB1_LO, `IOB_IRQB1_HI); // [R14]
		hit_b[0] = io_write && in_range(dec_addr, `IOB_TMR_LO, `IOB_TMR_HI); // [R15]
		// Nothing traps unless the global enable is on and a real I/O cycle runs
		hit_a = hit_a & trap_enable_a_reg & {8{io_cyc & break_enable}}; // [R23] [R16] [R19]
		hit_b = hit_b & trap_enable_b_reg & {8{io_cyc & break_enable}}; // [R16]
	end

	// Status next: read clears, but a same-cycle hit survives the clear
	always @*
	begin
		status_a_next = trap_status_a_reg;
		status_b_next = trap_status_b_reg;
		if (data_rd && index_reg == `IOB_IDX_STATUS_A)
			status_a_next = 8'h00; // [R17]
		if (data_rd && index_reg == `IOB_IDX_STATUS_B)
			status_b_next = 8'h00; // [R17]
		status_a_next = status_a_next | hit_a; // [R16] [R19]
		status_b_next = status_b_next | hit_b; // [R16]
	end

	// Read mux for the data port, bit 7 of status A reads as zero
	always @*
	begin
		case (index_reg)
			`IOB_IDX_ENABLE_A: rdata_next = trap_enable_a_reg;
			`IOB_IDX_ENABLE_B: rdata_next = trap_enable_b_reg;
			`IOB_IDX_STATUS_A: rdata_next = {1'b0, trap_status_a_reg[6:0]};
			`IOB_IDX_STATUS_B: rdata_next = trap_status_b_reg;
			`IOB_IDX_W2_HI: rdata_next = window2_base_high_reg;
			`IOB_IDX_W2_LO: rdata_next = window2_base_low_size_reg;
			`IOB_IDX_W1_HI: rdata_next = window1_base_high_reg;
			`IOB_IDX_W1_LO: rdata_next = window1_base_low_size_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// Register file writes; windows should be set before their enables
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			index_reg <= 8'h00;
			trap_enable_a_reg <= `IOB_MASK_RESET;
			trap_enable_b_reg <= `IOB_MASK_RESET;
			window2_base_high_reg <= `IOB_WIN_RESET;
			window2_base_low_size_reg <= `IOB_WIN_RESET;
			window1_base_high_reg <= `IOB_WIN_RESET;
			window1_base_low_size_reg <= `IOB_WIN_RESET;
		end
		else
		begin
			if (idx_wr)
				index_reg <= io_wdata;
			if (data_wr)
			begin
				case (index_reg)
					`IOB_IDX_ENABLE_A:
						if (mask_wr_ok)
							trap_enable_a_reg <= io_wdata; // [R24]
					`IOB_IDX_ENABLE_B:
						if (mask_wr_ok)
							trap_enable_b_reg <= io_wdata; // [R24]
					`IOB_IDX_W2_HI: window2_base_high_reg <= io_wdata;
					`IOB_IDX_W2_LO: window2_base_low_size_reg <= io_wdata;
					`IOB_IDX_W1_HI: window1_base_high_reg <= io_wdata;
					`IOB_IDX_W1_LO: window1_base_low_size_reg <= io_wdata;
					default: index_reg <= index_reg;
				endcase
			end
		end
	end

	// Status, interrupt pin and summary flag
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			trap_status_a_reg <= `IOB_STAT_RESET;
			trap_status_b_reg <= `IOB_STAT_RESET;
			mgmt_irq_n <= 1'b1;
			any_break_pending <= 1'b0;
			io_rdata <= 8'h00;
			io_rvalid <= 1'b0;
		end
		else
		begin
			trap_status_a_reg <= status_a_next;
			trap_status_b_reg <= status_b_next;
			// Interrupt is a one-cycle low pulse per trapped cycle; the processor latches it
			mgmt_irq_n <= ~(|hit_a | |hit_b); // [R1] [R2]
			any_break_pending <= (|status_a_next) | (|status_b_next) | timer_flags_any; // [R18]
			io_rvalid <= data_rd;
			if (data_rd)
				io_rdata <= rdata_next;
		end
	end
endmodule // iob_break_trap

// ===== verification/iob_break_trap_assertions.sv
// Purpose: port checker for the I/O break trap
// Assumes: bound to iob_break_trap from the bench
// Notes: range decodes are judged by the bench, this guards timing
`timescale 1ns/100ps
module iob_chk
#(
	parameter [15:0] DATA_PORT = 16'h00ed
)
(
	// Clock and reset
	input wire mclk,
	input wire reset,
	// Bus cycle and answer
	input wire io_strobe,
	input wire io_cycle,
	input wire io_write,
	input wire [15:0] io_addr,
	input wire [7:0] io_rdata,
	input wire io_rvalid,
	// Controls and outputs
	input wire break_enable,
	input wire timer_flags_any,
	input wire mgmt_irq_n,
	input wire any_break_pending
);
	// Data port read, the only cycle that answers or clears status
	wire dread = io_strobe && io_cycle && !io_write && io_addr == DATA_PORT;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_irq_when_off: assert property (!break_enable |=> mgmt_irq_n)
		else $error("irq while traps off");
	a_irq_on_memory: assert property (io_strobe && !io_cycle |=> mgmt_irq_n)
		else $error("irq on memory cycle");
	a_irq_no_cycle: assert property (!io_strobe |=> mgmt_irq_n)
		else $error("irq without a cycle");
	a_irq_sets_flag: assert property (!mgmt_irq_n |-> any_break_pending)
		else $error("irq without pending flag");
	a_timer_pending: assert property (timer_flags_any |=> any_break_pending)
		else $error("timer flag not summarised");
	a_pending_clear: assert property ($fell(any_break_pending) |-> $past(dread) || $past(timer_flags_any, 2))
		else $error("pending fell without a read");
	a_read_answer: assert property (dread |=> io_rvalid)
		else $error("no answer to data read");
	a_answer_cause: assert property (io_rvalid |-> $past(dread))
		else $error("answer without data read");
	a_rdata_holds: assert property (!io_rvalid |-> $stable(io_rdata))
		else $error("read data changed");
	c_trap: cover property (!mgmt_irq_n);
	c_read: cover property (io_rvalid);
	c_clear: cover property ($fell(any_break_pending));
endmodule // iob_chk

// ===== verification/iob_cpu_model.sv
// Purpose: processor side issuing single I/O or memory bus cycles
// Assumes: launched on a falling edge, taken on the next rising edge
// Notes: released address and data lines show inverted values so stale data cannot pass
`timescale 1ns/100ps
module iob_cpu_model
(
	// Clock
	input wire mclk,
	// Bus cycle
	output logic io_strobe,
	output logic io_cycle,
	output logic io_write,
	output logic [15:0] io_addr,
	output logic [7:0] io_wdata,
	// Answer
	input wire [7:0] io_rdata,
	input wire io_rvalid
);
	logic [7:0] rd_last;
	logic rv_last;
	// Idle bus at time zero
	initial
	begin
		io_strobe = 1'b0;
		io_cycle = 1'b0;
		io_write = 1'b0;
		io_addr = 16'hffff;
		io_wdata = 8'hff;
	end
	// One cycle, qualifiers held through the taking edge
	task automatic cyc(input logic c, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		io_strobe = 1'b1;
		io_cycle = c;
		io_write = w;
		io_addr = a;
		io_wdata = d;
		@(negedge mclk);
		rd_last = io_rdata;
		rv_last = io_rvalid;
		io_strobe = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
endmodule // iob_cpu_model

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the I/O break trap
// Assumes: 100 MHz mclk, inputs changed on the falling edge
// Notes: table rows cover fixed decodes, hand tests the rest
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {logic [15:0] en; logic w; logic [15:0] a; logic hit;} iob_row_t;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic break_enable = 1'b1;
	logic mgmt_lock = 1'b0;
	logic dec10 = 1'b0;
	logic timer_any = 1'b0;
	logic pin_n = 1'b1;
	wire io_strobe, io_cycle, io_write, io_rvalid, irq_n, pend;
	wire [15:0] io_addr;
	wire [7:0] io_wdata, io_rdata;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	int i;
	iob_row_t rows [0:19];
	iob_cpu_model cpu (.mclk(mclk), .io_strobe(io_strobe), .io_cycle(io_cycle), .io_write(io_write),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
	iob_break_trap dut (.mclk(mclk), .reset(reset), .io_strobe(io_strobe), .io_cycle(io_cycle),
		.io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .break_enable(break_enable), .mgmt_lock(mgmt_lock),
		.io_decode_width_sel(dec10), .timer_flags_any(timer_any), .mgmt_irq_pin_n(pin_n),
		.mgmt_irq_n(irq_n), .any_break_pending(pend));
	always #5 mclk = ~mclk;
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		cpu.cyc(1'b1, 1'b1, 16'h00ec, idx);
		cpu.cyc(1'b1, 1'b1, 16'h00ed, d);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		cpu.cyc(1'b1, 1'b1, 16'h00ec, idx);
		cpu.cyc(1'b1, 1'b0, 16'h00ed, 8'h00);
		chk(cpu.rv_last, 1'b1);
		chk(cpu.rd_last, exp);
	endtask
	// One access, interrupt seen in the cycle after the taking edge
	task automatic acc(input logic c, input logic w, input logic [15:0] a, input logic hit);
		cpu.cyc(c, w, a, 8'h5a);
		chk(irq_n, !hit);
	endtask
	initial
	begin
		rows = '{{16'h1000, 1'b0, 16'h01f0, 1'b1}, {16'h1000, 1'b1, 16'h03f6, 1'b1},
			{16'h0800, 1'b0, 16'h03f5, 1'b1}, {16'h0400, 1'b1, 16'h037a, 1'b1},
			{16'h0400, 1'b0, 16'h037b, 1'b0}, {16'h0200, 1'b0, 16'h02f8, 1'b1},
			{16'h0100, 1'b1, 16'h03ff, 1'b1}, {16'h0080, 1'b0, 16'h0064, 1'b1},
			{16'h0080, 1'b1, 16'h0061, 1'b0}, {16'h0040, 1'b1, 16'h0060, 1'b1},
			{16'h0040, 1'b0, 16'h0060, 1'b0}, {16'h0020, 1'b1, 16'h0070, 1'b1},
			{16'h0020, 1'b0, 16'h0070, 1'b0}, {16'h0010, 1'b1, 16'h00de, 1'b1},
			{16'h0010, 1'b1, 16'h00c1, 1'b0}, {16'h0008, 1'b1, 16'h000f, 1'b1},
			{16'h0004, 1'b1, 16'h0021, 1'b1}, {16'h0002, 1'b1, 16'h00a0, 1'b1},
			{16'h0001, 1'b1, 16'h0043, 1'b1}, {16'hfbff, 1'b1, 16'h037a, 1'b0}};
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		rdc(8'h81, 8'h00);
		rdc(8'h83, 8'h00);
		rdc(8'h8f, 8'h00);
		wr(8'h81, 8'ha5);
		rdc(8'h81, 8'ha5);
		for (i = 0; i < 20; i++)
		begin
			wr(8'h80, rows[i].en[15:8]);
			wr(8'h81, rows[i].en[7:0]);
			acc(1'b1, rows[i].w, rows[i].a, rows[i].hit);
			rdc(8'h82, rows[i].hit ? rows[i].en[15:8] : 8'h00);
			rdc(8'h83, rows[i].hit ? rows[i].en[7:0] : 8'h00);
			chk(pend, 1'b0);
		end
		// Second window at every size, last byte in and first byte out
		for (i = 0; i < 4; i++)
		begin
			wr(8'h80, 8'h00);
			wr(8'h84, 8'h02);
			wr(8'h85, 8'h40 | 8'(i));
			wr(8'h80, 8'h40);
			acc(1'b1, 1'b0, 16'h0240 + (16'h0004 << i) - 16'h0001, 1'b1);
			acc(1'b1, 1'b1, 16'h0240 + (16'h0004 << i), 1'b0);
			rdc(8'h82, 8'h40);
		end
		// First window base, then CMOS index address, with upper bits that only count in 16-bit decode
		wr(8'h80, 8'h00);
		wr(8'h86, 8'hfe);
		wr(8'h87, 8'h40);
		wr(8'h80, 8'h20);
		acc(1'b1, 1'b0, 16'h0240, 1'b0);
		acc(1'b1, 1'b0, 16'hfe41, 1'b1);
		dec10 = 1'b1;
		acc(1'b1, 1'b1, 16'h0242, 1'b1);
		rdc(8'h82, 8'h20);
		wr(8'h81, 8'h20);
		acc(1'b1, 1'b1, 16'h0470, 1'b1);
		rdc(8'h83, 8'h20);
		dec10 = 1'b0;
		// Both disk traps armed: shared address 3F6h sets only the hard disk flag
		wr(8'h80, 8'h18);
		acc(1'b1, 1'b1, 16'h03f6, 1'b1);
		rdc(8'h82, 8'h10);
		// Memory cycles and a cleared global enable never trap
		wr(8'h80, 8'h04);
		acc(1'b0, 1'b1, 16'h0378, 1'b0);
		break_enable = 1'b0;
		acc(1'b1, 1'b1, 16'h0378, 1'b0);
		break_enable = 1'b1;
		rdc(8'h82, 8'h00);
		// Summary flag needs both status registers read
		wr(8'h81, 8'h01);
		acc(1'b1, 1'b1, 16'h0378, 1'b1);
		acc(1'b1, 1'b1, 16'h0043, 1'b1);
		rdc(8'h82, 8'h04);
		chk(pend, 1'b1);
		rdc(8'h82, 8'h00);
		rdc(8'h83, 8'h01);
		chk(pend, 1'b0);
		timer_any = 1'b1;
		@(negedge mclk);
		chk(pend, 1'b1);
		timer_any = 1'b0;
		// Lock refuses mask writes until the interrupt pin is active
		mgmt_lock = 1'b1;
		wr(8'h81, 8'hff);
		rdc(8'h81, 8'h01);
		pin_n = 1'b0;
		repeat (5) @(negedge mclk);
		wr(8'h81, 8'h3c);
		rdc(8'h81, 8'h3c);
		pin_n = 1'b1;
		mgmt_lock = 1'b0;
		// Leave a flag set so the mid-run reset has something to clear
		acc(1'b1, 1'b1, 16'h0070, 1'b1);
		reset = 1'b1;
		@(negedge mclk);
		reset = 1'b0;
		chk(pend, 1'b0);
		chk(irq_n, 1'b1);
		rdc(8'h83, 8'h00);
		rdc(8'h81, 8'h00);
		print_verdict();
	end
endmodule // tb_top
bind iob_break_trap iob_chk #(.DATA_PORT(DATA_PORT)) u_chk (.mclk(mclk), .reset(reset), .io_strobe(io_strobe),
	.io_cycle(io_cycle), .io_write(io_write), .io_addr(io_addr), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
	.break_enable(break_enable), .timer_flags_any(timer_flags_any), .mgmt_irq_n(mgmt_irq_n),
	.any_break_pending(any_break_pending));
